// ===== hw/bss_map.vh
// constants for the sensorless startup sequencer
`ifndef BSS_MAP_VH
`define BSS_MAP_VH
`define BSS_ST_OPEN      3'h0
`define BSS_ST_CAPEN     3'h1
`define BSS_ST_AVG       3'h2
`define BSS_ST_HANDOVER  3'h3
`define BSS_ST_CLOSED    3'h4
`define BSS_DUTY_W       8
`define BSS_DUTY_FIXED   8'h40
`define BSS_DUTY_RST     8'h40
`define BSS_CT_W         20
`define BSS_COMM_NS      1000000
`define BSS_COMM_CYC     (`BSS_COMM_NS / 5)
`define BSS_QTR_CYC      (`BSS_COMM_CYC / 4)
`define BSS_START_NS     20000000
`define BSS_START_CYC    (`BSS_START_NS / 5)
`define BSS_MISS_CYC     (`BSS_COMM_CYC * 2)
`define BSS_MISS_MAX     3
`define BSS_ZCD_RST      20'h00000
`define BSS_TOL_PCT      30
`define BSS_HIST         8
`endif

// ===== hw/bss_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module bss_sync (
    input  wire ref_clk,
    input  wire resetn,
    input  wire din,
    output reg  dout
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    always @(posedge ref_clk) begin
        if (!resetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            dout   <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // change accepted once stages two and three agree
            if (s2_reg == s3_reg) begin
                dout <= s3_reg;
            end
        end
    end
endmodule

// ===== hw/bss_fsm.v
// sensorless bldc startup and lock sequencer
// Functional notes
// (R1) open loop: fixed duty, constrained commutation period
// (R2) open loop: four current samples per step
// (R3) debug holds open loop until command
// (R4) normal: leave open loop after start time
// (R5) capture-enable state enables both edge captures
// (R6) capture-enable advances to averaging automatically
// (R7) averaging: timestamp edges, history, running average
// (R8) advance when revolution within 30% of six periods
// (R9) handover waits next constrained commutation
// (R10) closed loop duty from pi regulator
// (R11) closed loop delay from edge history
// (R12) missing edge forces emergency commutation
// (R13) repeated misses return to open loop
// (R14) capture disabled during open loop
// (R15) commands force closed loop or capture-enable; capture-enable is forced only from open loop or closed loop
// (R16) startup commands step delay and duty
// (R17) miss window and miss count are parameters
// (R18) emergency commutation advances exactly one step
`timescale 1ns/1ps
`include "bss_map.vh"
module bss_fsm #(
    parameter START_CYC = `BSS_START_CYC,
    parameter MISS_CYC  = `BSS_MISS_CYC,
    parameter MISS_MAX  = `BSS_MISS_MAX
) (
    input  wire       ref_clk,
    input  wire       resetn,
    input  wire       bemf_comparator,
    input  wire       dir_ccw,
    input  wire       debug_mode,
    input  wire       cmd_force_closed,
    input  wire       cmd_force_capen,
    input  wire       cmd_delay_up,
    input  wire       cmd_delay_down,
    input  wire       cmd_duty_up,
    input  wire       cmd_duty_down,
    input  wire [7:0] pi_duty,
    output reg  [2:0] comm_step,
    output reg  [7:0] duty,
    output reg        capture_en,
    output reg        sample_trig,
    output reg        emergency_comm,
    output reg  [2:0] seq_state,
    output reg        locked
);
    localparam CW = `BSS_CT_W;
    localparam HN = `BSS_HIST;
    // tolerance window on one electrical revolution, in percent-scaled cycles
    localparam [31:0] REV_LO = (100 - `BSS_TOL_PCT) * 6 * `BSS_COMM_CYC;
    localparam [31:0] REV_HI = (100 + `BSS_TOL_PCT) * 6 * `BSS_COMM_CYC;

    wire          cmp_s;
    reg           cmp_d_reg;
    reg  [2:0]    state_reg;
    reg  [CW-1:0] comm_cnt_reg;
    reg  [31:0]   start_cnt_reg;
    reg  [CW-1:0] stamp_reg;
    reg  [CW-1:0] hist [0:HN-1];
    reg  [2:0]    hptr_reg;
    reg  [3:0]    hfill_reg;
    reg  [CW+2:0] hsum_reg;
    reg  [CW-1:0] zcd_reg;
    reg  [CW-1:0] zc_cnt_reg;
    reg           zc_pend_reg;
    reg  [31:0]   miss_cnt_reg;
    reg  [7:0]    misses_reg;
    reg  [7:0]    duty_adj_reg;
    reg  [1:0]    handover_reg;
    reg  [1:0]    q_reg;
    integer       i;

    wire edge_evt = capture_en && (cmp_s != cmp_d_reg);
    wire comm_tick = (comm_cnt_reg == (`BSS_COMM_CYC - 1));
    wire [CW-1:0] avg_half = hsum_reg[CW+2:3];
    wire [CW+3:0] rev = {1'b0, avg_half, 3'h0} + {2'h0, avg_half, 2'h0};
    // startup delay trim rides on top of half the averaged half interval
    wire [CW:0]   zc_sum = {2'h0, avg_half[CW-1:1]} + {1'b0, zcd_reg};

    function [2:0] step_next;
        input [2:0] s;
        input       ccw;
        begin
            if (ccw) begin
                step_next = (s == 3'h0) ? 3'h5 : s - 3'h1;
            end else begin
                step_next = (s == 3'h5) ? 3'h0 : s + 3'h1;
            end
        end
    endfunction

    function [7:0] sat_step;
        input [7:0] v;
        input       up;
        input       dn;
        begin
            sat_step = v;
            if (up && v != 8'hff) begin
                sat_step = v + 8'h01;
            end else if (dn && v != 8'h00) begin
                sat_step = v - 8'h01;
            end
        end
    endfunction

    // quarter points of the constrained period, fixed to the schedule
    function is_quarter;
        input [CW-1:0] c;
        begin
            is_quarter = (c == {CW{1'b0}}) ||
                         (c == `BSS_QTR_CYC) ||
                         (c == 2 * `BSS_QTR_CYC) ||
                         (c == 3 * `BSS_QTR_CYC);
        end
    endfunction

    // kept in 32 bits so the scaled revolution cannot wrap
    function rev_in_window;
        input [CW+3:0] r;
        reg   [31:0]   scaled;
        begin
            scaled        = {8'h00, r} * 32'h00000064;
            rev_in_window = (scaled >= REV_LO) && (scaled <= REV_HI);
        end
    endfunction

    bss_sync u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .din     (bemf_comparator),
        .dout    (cmp_s)
    );

    always @(posedge ref_clk) begin
        if (!resetn) begin
            state_reg      <= `BSS_ST_OPEN;
            cmp_d_reg      <= 1'b0;
            comm_cnt_reg   <= {CW{1'b0}};
            start_cnt_reg  <= 32'h00000000;
            stamp_reg      <= {CW{1'b0}};
            hptr_reg       <= 3'h0;
            hfill_reg      <= 4'h0;
            hsum_reg       <= {(CW+3){1'b0}};
            zcd_reg        <= `BSS_ZCD_RST;
            zc_cnt_reg     <= {CW{1'b0}};
            zc_pend_reg    <= 1'b0;
            miss_cnt_reg   <= 32'h00000000;
            misses_reg     <= 8'h00;
            duty_adj_reg   <= `BSS_DUTY_FIXED;
            handover_reg   <= 2'h0;
            q_reg          <= 2'h0;
            comm_step      <= 3'h0;
            duty           <= `BSS_DUTY_RST;
            capture_en     <= 1'b0;
            sample_trig    <= 1'b0;
            emergency_comm <= 1'b0;
            seq_state      <= `BSS_ST_OPEN;
            locked         <= 1'b0;
            for (i = 0; i < HN; i = i + 1) begin
                hist[i] <= {CW{1'b0}};
            end
        end else begin
            cmp_d_reg      <= cmp_s;
            sample_trig    <= 1'b0;
            emergency_comm <= 1'b0;
            seq_state      <= state_reg;
            locked         <= (state_reg == `BSS_ST_CLOSED);
            // (R14) no capture in open loop
            capture_en     <= (state_reg != `BSS_ST_OPEN);

            if (state_reg != `BSS_ST_CLOSED) begin
                // (R1) constrained commutation schedule
                comm_cnt_reg <= comm_tick ? {CW{1'b0}} : comm_cnt_reg + 1'b1;
                if (comm_tick) begin
                    comm_step <= step_next(comm_step, dir_ccw);
                end
                // (R2) four samples per step, at quarter points
                if (is_quarter(comm_cnt_reg)) begin
                    sample_trig <= 1'b1;
                end
                // (R16) startup delay and duty steps
                duty_adj_reg <= sat_step(duty_adj_reg, cmd_duty_up, cmd_duty_down);
                if (cmd_delay_up) begin
                    zcd_reg <= zcd_reg + 1'b1;
                end else if (cmd_delay_down && zcd_reg != 0) begin
                    zcd_reg <= zcd_reg - 1'b1;
                end
                // (R1) fixed duty, no regulation
                duty <= duty_adj_reg;
            end else begin
                // (R10) pi regulator drives duty
                duty <= pi_duty;
            end

            // (R7) timestamp edges into history
            stamp_reg <= edge_evt ? {CW{1'b0}} : stamp_reg + 1'b1;
            if (edge_evt && state_reg >= `BSS_ST_AVG) begin
                hist[hptr_reg] <= stamp_reg;
                hptr_reg       <= hptr_reg + 3'h1;
                hsum_reg       <= hsum_reg + stamp_reg - hist[hptr_reg];
                if (hfill_reg != HN) begin
                    hfill_reg <= hfill_reg + 4'h1;
                end
            end

            case (state_reg)
                `BSS_ST_OPEN: begin
                    start_cnt_reg <= start_cnt_reg + 32'h1;
                    // (R3) debug waits for command
                    if (cmd_force_closed) begin
                        state_reg <= `BSS_ST_CLOSED;
                        // stale miss count from an earlier lock must not carry over
                        miss_cnt_reg <= 32'h0;
                        misses_reg   <= 8'h00;
                        zc_pend_reg  <= 1'b0;
                    end else if (cmd_force_capen) begin
                        state_reg <= `BSS_ST_CAPEN;
                    // (R4) timed exit in normal mode
                    end else if (!debug_mode && start_cnt_reg >= START_CYC - 1) begin
                        state_reg <= `BSS_ST_CAPEN;
                    end
                end
                `BSS_ST_CAPEN: begin
                    // (R5) capture enabled; (R6) auto advance
                    hfill_reg <= 4'h0;
                    hsum_reg  <= {(CW+3){1'b0}};
                    // fresh timestamps, an old count would skew the average
                    stamp_reg <= {CW{1'b0}};
                    state_reg <= `BSS_ST_AVG;
                end
                `BSS_ST_AVG: begin
                    // (R8) revolution = 12 half-periods vs 6 periods
                    if (hfill_reg == HN && rev_in_window(rev)) begin
                        state_reg <= `BSS_ST_HANDOVER;
                    end
                end
                `BSS_ST_HANDOVER: begin
                    // (R9) wait for scheduled commutation
                    if (comm_tick) begin
                        state_reg    <= `BSS_ST_CLOSED;
                        miss_cnt_reg <= 32'h0;
                        misses_reg   <= 8'h00;
                        zc_pend_reg  <= 1'b0;
                    end
                end
                `BSS_ST_CLOSED: begin
                    if (cmd_force_capen) begin
                        state_reg <= `BSS_ST_CAPEN;
                    end
                    // (R11) delay from history average
                    if (edge_evt) begin
                        zc_pend_reg  <= 1'b1;
                        // (R16) trimmed delay saturates instead of wrapping
                        zc_cnt_reg   <= zc_sum[CW] ? {CW{1'b1}} : zc_sum[CW-1:0];
                        miss_cnt_reg <= 32'h0;
                        misses_reg   <= 8'h00;
                    end else if (zc_pend_reg) begin
                        if (zc_cnt_reg == 0) begin
                            zc_pend_reg <= 1'b0;
                            comm_step   <= step_next(comm_step, dir_ccw);
                        end else begin
                            zc_cnt_reg <= zc_cnt_reg - 1'b1;
                        end
                    end
                    if (!edge_evt) begin
                        miss_cnt_reg <= miss_cnt_reg + 32'h1;
                    end
                    // (R12) (R17) missing edge window
                    if (!edge_evt && miss_cnt_reg >= MISS_CYC - 1) begin
                        miss_cnt_reg   <= 32'h0;
                        emergency_comm <= 1'b1;
                        // (R18) advance exactly one step
                        comm_step      <= step_next(comm_step, dir_ccw);
                        misses_reg     <= misses_reg + 8'h01;
                        // (R13) repeated misses fall back
                        if (misses_reg >= MISS_MAX - 1) begin
                            state_reg     <= `BSS_ST_OPEN;
                            start_cnt_reg <= 32'h0;
                            comm_cnt_reg  <= {CW{1'b0}};
                        end
                    end
                end
                default: begin
                    state_reg <= `BSS_ST_OPEN;
                end
            endcase
            if (state_reg != `BSS_ST_OPEN && state_reg != `BSS_ST_CLOSED &&
                cmd_force_closed) begin
                // (R15) forced entry into closed loop
                state_reg    <= `BSS_ST_CLOSED;
                miss_cnt_reg <= 32'h0;
                misses_reg   <= 8'h00;
                zc_pend_reg  <= 1'b0;
            end
        end
    end
endmodule

// ===== verification/bss_fsm_monitor.sv
// assertion checker on the sequencer ports
`timescale 1ns/1ps
`include "bss_map.vh"
module bss_fsm_mon #(
    parameter START_CYC = 100,
    parameter MISS_CYC  = 50,
    parameter MISS_MAX  = 3
) (
    input wire       ref_clk,
    input wire       resetn,
    input wire       bemf_comparator,
    input wire       dir_ccw,
    input wire       debug_mode,
    input wire       cmd_force_closed,
    input wire       cmd_force_capen,
    input wire       cmd_delay_up,
    input wire       cmd_delay_down,
    input wire       cmd_duty_up,
    input wire       cmd_duty_down,
    input wire [7:0] pi_duty,
    input wire [2:0] comm_step,
    input wire [7:0] duty,
    input wire       capture_en,
    input wire       sample_trig,
    input wire       emergency_comm,
    input wire [2:0] seq_state,
    input wire       locked
);
    reg  [2:0] prev_step_reg;
    reg        prev_ccw_reg;
    wire [2:0] step_fwd = (prev_step_reg == 3'h5) ? 3'h0 : prev_step_reg + 3'h1;
    wire [2:0] step_rev = (prev_step_reg == 3'h0) ? 3'h5 : prev_step_reg - 3'h1;
    wire       no_force = !cmd_force_closed && !cmd_force_capen;
    wire       is_open  = (seq_state == `BSS_ST_OPEN);
    always @(posedge ref_clk) begin
        prev_step_reg <= comm_step;
        prev_ccw_reg  <= dir_ccw;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    open_cap_off_a: assert property (is_open && $past(is_open) |-> !capture_en)
        else $error("capture enabled in open loop");
    closed_duty_a: assert property (
        locked && $past(locked) && $past(locked, 2) && $stable(pi_duty)
        && $past(pi_duty) == $past(pi_duty, 2) |-> duty == pi_duty)
        else $error("closed loop duty not from regulator");
    emerg_step_a: assert property (emergency_comm |-> comm_step == (prev_ccw_reg ? step_rev : step_fwd))
        else $error("emergency step not one step");
    emerg_locked_a: assert property (emergency_comm |-> $past(locked))
        else $error("emergency outside closed loop");
    duty_hold_a: assert property (
        is_open && $past(is_open) && $past(is_open, 2) && $past(no_force)
        && !$past(cmd_duty_up, 2) && !$past(cmd_duty_down, 2) |-> $stable(duty))
        else $error("open loop duty moved");
    duty_step_a: assert property (
        is_open && $past(is_open) && $past(is_open, 2) && $past(no_force)
        && $past(cmd_duty_up, 2) && !$past(cmd_duty_down, 2) && $past(duty) != 8'hff
        |-> duty == $past(duty) + 8'h01)
        else $error("duty step wrong");
    capen_auto_a: assert property (
        seq_state == `BSS_ST_CAPEN && no_force && $past(no_force)
        |=> seq_state == `BSS_ST_AVG)
        else $error("capture state did not advance");
    debug_hold_a: assert property (
        is_open && debug_mode && $past(debug_mode) && no_force
        && $past(no_force) |=> is_open)
        else $error("left open loop in debug");
    trig_pulse_a: assert property (sample_trig |=> !sample_trig)
        else $error("sample trigger too long");
    cover property (locked ##1 emergency_comm);
    cover property (seq_state == `BSS_ST_AVG);
    cover property (sample_trig);
endmodule

// ===== verification/bss_motor_model.sv
// comparator model: a spinning rotor toggles the back-emf level
`timescale 1ns/1ps
module bss_motor_model #(
    parameter HALF_CYC = 20
) (
    input  wire ref_clk,
    input  wire spin_en,
    output reg  bemf_comparator
);
    integer cnt_reg = 0;
    initial bemf_comparator = 1'b0;
    // stopped rotor gives no zero crossings, so the level freezes
    always @(posedge ref_clk) begin
        if (spin_en && cnt_reg == HALF_CYC - 1) begin
            cnt_reg <= 0;
            bemf_comparator <= ~bemf_comparator;
        end else if (spin_en) begin
            cnt_reg <= cnt_reg + 1;
        end
    end
endmodule

// ===== verification/bss_tb.sv
// self-checking bench for the startup sequencer
`timescale 1ns/1ps
`include "bss_map.vh"
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", nm, e, a); end end
module tb;
    localparam START = 100;
    localparam MISS  = 50;
    reg        ref_clk = 1'b0;
    reg        resetn = 1'b0;
    reg        dir_ccw = 1'b0;
    reg        debug_mode = 1'b0;
    reg        spin_en = 1'b0;
    reg  [5:0] cmd = 6'h00;
    reg  [7:0] pi_duty = 8'h00;
    wire       bemf, capture_en, sample_trig, emergency_comm, locked;
    wire [2:0] comm_step, seq_state;
    wire [7:0] duty;
    int        errors = 0;
    int        n_tests = 0;
    int        n_trig = 0;
    int        n_comm = 0;
    int        exp_duty, exp_step, i, j;
    always #2.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (sample_trig === 1'b1) n_trig++;
    bss_motor_model #(.HALF_CYC(20)) motor_u (.ref_clk(ref_clk), .spin_en(spin_en),
        .bemf_comparator(bemf));
    bss_fsm #(.START_CYC(START), .MISS_CYC(MISS), .MISS_MAX(`BSS_MISS_MAX)) dut_u (
        .ref_clk(ref_clk), .resetn(resetn), .bemf_comparator(bemf), .dir_ccw(dir_ccw),
        .debug_mode(debug_mode), .cmd_force_closed(cmd[0]), .cmd_force_capen(cmd[1]),
        .cmd_delay_up(cmd[2]), .cmd_delay_down(cmd[3]), .cmd_duty_up(cmd[4]),
        .cmd_duty_down(cmd[5]), .pi_duty(pi_duty), .comm_step(comm_step), .duty(duty),
        .capture_en(capture_en), .sample_trig(sample_trig), .emergency_comm(emergency_comm),
        .seq_state(seq_state), .locked(locked));
    task tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task pulse(input int b);
        cmd[b] = 1'b1;
        tick(1);
        cmd[b] = 1'b0;
        tick(1);
    endtask
    task finish_test;
        if (errors == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        finish_test();
    end
    initial begin
        i = $urandom(32'hf008aaa5);
        tick(6);
        resetn = 1'b1;
        tick(1);
        `CHK("duty", `BSS_DUTY_FIXED, duty)
        `CHK("cap", 1'b0, capture_en)
        debug_mode = 1'b1;
        tick(51000);
        `CHK("state", `BSS_ST_OPEN, seq_state)
        `CHK("step", 3'h0, comm_step)
        `CHK("trig", 2, n_trig)
        exp_duty = `BSS_DUTY_FIXED;
        for (i = 0; i < 6; i++) begin
            j = $urandom_range(5, 4);
            pulse(j);
            exp_duty += (j == 4) ? 1 : -1;
            `CHK("duty", exp_duty[7:0], duty)
            pulse(2 + (j & 1));
        end
        pulse(1);
        tick(3);
        `CHK("state", `BSS_ST_AVG, seq_state)
        `CHK("cap", 1'b1, capture_en)
        pi_duty = $urandom;
        spin_en = 1'b1;
        pulse(0);
        tick(3);
        `CHK("lock", 1'b1, locked)
        `CHK("duty", pi_duty, duty)
        pulse(4);
        pi_duty = $urandom;
        tick(3);
        `CHK("duty", pi_duty, duty)
        // one commutation per comparator edge once the history has settled
        tick(200);
        for (i = 0; i < 400; i++) begin
            exp_step = comm_step;
            tick(1);
            if (comm_step !== exp_step) n_comm++;
        end
        `CHK("comm", 1'b1, n_comm >= 19 && n_comm <= 21)
        dir_ccw = $urandom;
        spin_en = 1'b0;
        // last step seen before the forced one is the reference point
        for (i = 0; i < MISS * 2 && emergency_comm !== 1'b1; i++) begin
            exp_step = comm_step;
            tick(1);
        end
        exp_step = dir_ccw ? (exp_step + 5) % 6 : (exp_step + 1) % 6;
        `CHK("emerg", 1'b1, emergency_comm)
        `CHK("step", exp_step[2:0], comm_step)
        for (i = 0; i < MISS * 8 && seq_state !== `BSS_ST_OPEN; i++) tick(1);
        `CHK("state", `BSS_ST_OPEN, seq_state)
        tick(2);
        `CHK("cap", 1'b0, capture_en)
        debug_mode = 1'b0;
        tick(START + 10);
        `CHK("state", `BSS_ST_AVG, seq_state)
        finish_test();
    end
endmodule
bind bss_fsm bss_fsm_mon #(.START_CYC(START_CYC), .MISS_CYC(MISS_CYC), .MISS_MAX(MISS_MAX)) mon_u (
    .ref_clk(ref_clk), .resetn(resetn), .bemf_comparator(bemf_comparator), .dir_ccw(dir_ccw),
    .debug_mode(debug_mode), .cmd_force_closed(cmd_force_closed),
    .cmd_force_capen(cmd_force_capen), .cmd_delay_up(cmd_delay_up),
    .cmd_delay_down(cmd_delay_down), .cmd_duty_up(cmd_duty_up), .cmd_duty_down(cmd_duty_down),
    .pi_duty(pi_duty), .comm_step(comm_step), .duty(duty), .capture_en(capture_en),
    .sample_trig(sample_trig), .emergency_comm(emergency_comm), .seq_state(seq_state),
    .locked(locked));
